// ### bench/cpu_exception_sequencer_tb_top.sv
// Self-checking bench of the exception sequencer
`timescale 1ns/1ns
`default_nettype none
module cpu_exception_sequencer_tb_top;
   import exs_pkg::*;
   logic ref_clk, rst, chip_clear_in_n, slow, int_pending, int_is_nmi;
   logic int_mode_set, ctl_write, bus_ack, bus_req, bus_we, bus_long;
   logic cpu_halt, periph_init, pc_load, int_ack, exc_active, vec_error;
   logic wdt_overflow, instr_done, return_from_exception_instr;
   logic and_to_control_instr, or_to_control_instr, xor_to_control_instr;
   logic load_control_instr, trap_always_instr, rd_long;
   logic [1:0]  trap_num, int_mode_in, int_mode;
   logic [7:0]  int_vec, ccr_in, exr_in, flags, vec_num_out;
   logic [7:0]  condition_code_reg, extended_control_reg;
   logic [31:0] bus_rdata, bus_addr, bus_wdata, pc_out, rd_addr, wr_data;
   logic [3:0]  saves_seen;
   int          fail_count  = 0;
   int          comparisons = 0;
   int          cycles      = 0;
   assign {wdt_overflow, trap_always_instr, load_control_instr,
           xor_to_control_instr, or_to_control_instr, and_to_control_instr,
           return_from_exception_instr, instr_done} = flags;
   exs_sequencer dut (.*);
   exs_bus_model mem (.ref_clk(ref_clk), .slow(slow), .bus_req(bus_req),
      .bus_we(bus_we), .bus_addr(bus_addr), .bus_long(bus_long),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata), .rd_addr(rd_addr),
      .rd_long(rd_long), .saves_seen(saves_seen), .bus_wdata(bus_wdata),
      .wr_data(wr_data));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic check(input logic [31:0] seen, exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic pulse(input logic [7:0] fl);
      @(negedge ref_clk) flags = fl;
      @(negedge ref_clk) flags = 8'h00;
   endtask : pulse
   task automatic watch(output logic took, acked);
      took  = 1'b0;
      acked = 1'b0;
      repeat (3) begin
         took  = took | exc_active;
         acked = acked | int_ack;
         @(negedge ref_clk);
      end
   endtask : watch
   task automatic run_exc(input logic [7:0] vec, input logic [3:0] saves);
      logic [31:0] slot;
      slot = {22'h0, vec, 2'b00};
      for (int i = 0; i < 300 && pc_load !== 1'b1; i++) @(negedge ref_clk);
      check(pc_load, 1'b1, "pc load");
      check(pc_out, 32'h0000_1000 + slot, "pc");
      check(rd_addr, slot, "vector slot");
      check(rd_long, 1'b1, "longword fetch");
      check(saves_seen, saves, "saves first");
      check(vec_num_out, vec, "vector number");
      check(vec_error, 1'b0, "vector accepted");
      @(negedge ref_clk);
   endtask : run_exc
   task automatic reset_seq();
      for (int i = 0; i < 10 && periph_init !== 1'b1; i++)
         @(negedge ref_clk);
      check(periph_init, 1'b1, "peripheral init");
      run_exc(8'h00, 4'h0);
      check(condition_code_reg[7], 1'b1, "ccr mask");
      check(extended_control_reg[7], 1'b0, "trace");
      check(int_mode, 2'h0, "mode after reset");
      check(cpu_halt, 1'b0, "running");
   endtask : reset_seq
   task automatic pin_reset();
      logic bad;
      bad = 1'b0;
      @(negedge ref_clk) chip_clear_in_n = 1'b0;
      // pin held low for the run-time minimum
      for (int i = 0; i < 20; i++) begin
         @(negedge ref_clk);
         if (i >= 2) bad = bad | !cpu_halt | bus_req;
      end
      check(bad, 1'b0, "halt while pin low");
      chip_clear_in_n = 1'b1;
      reset_seq();
      $display("Test pin reset done");
   endtask : pin_reset
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_int();
      logic       took, acked;
      logic [8:0] kinds [5] = '{9'h120, 9'h010, 9'h017, 9'h020, 9'h076};
      int_pending = 1'b1;
      int_vec     = 8'h10;
      pulse(8'h01);
      watch(took, acked);
      check(took | acked, 1'b0, "int after reset");
      for (int k = 0; k < 5; k++) begin
         slow        = k[0];
         int_is_nmi  = kinds[k][8];
         int_vec     = kinds[k][7:0];
         int_pending = 1'b1;
         pulse(8'h01);
         watch(took, acked);
         check(acked, 1'b1, "int taken");
         int_pending = 1'b0;
         run_exc(kinds[k][8] ? 8'h07 : kinds[k][7:0], 4'h3);
      end
      int_is_nmi = 1'b0;
      $display("Test interrupts done");
   endtask : t_int
   task automatic t_ctl();
      logic took, acked;
      int_pending = 1'b1;
      int_vec     = 8'h13;
      for (int k = 0; k < 4; k++) begin
         pulse(8'h01 | (8'h04 << k));
         watch(took, acked);
         check(took | acked, 1'b0, "control instr");
      end
      pulse(8'h01);
      watch(took, acked);
      check(acked, 1'b1, "int after plain instr");
      int_pending = 1'b0;
      run_exc(8'h13, 4'h3);
      $display("Test control instructions done");
   endtask : t_ctl
   task automatic t_trap();
      logic took, acked;
      slow = 1'b1;
      for (int n = 0; n < 4; n++) begin
         trap_num = n[1:0];
         pulse(8'h40);
         watch(took, acked);
         check(took, 1'b1, "trap taken");
         run_exc(8'h08 + 8'(n), 4'h3);
      end
      slow = 1'b0;
      $display("Test traps done");
   endtask : t_trap
   task automatic t_trace();
      logic took, acked;
      exr_in = 8'h80;
      @(negedge ref_clk) ctl_write = 1'b1;
      @(negedge ref_clk) ctl_write = 1'b0;
      pulse(8'h01);
      watch(took, acked);
      check(took, 1'b0, "trace in mode 0");
      int_mode_in = 2'h2;
      @(negedge ref_clk) int_mode_set = 1'b1;
      @(negedge ref_clk) int_mode_set = 1'b0;
      pulse(8'h03);
      watch(took, acked);
      check(took, 1'b0, "trace after return");
      int_pending = 1'b1;
      int_vec     = 8'h11;
      pulse(8'h01);
      watch(took, acked);
      check(took, 1'b1, "trace taken");
      check(acked, 1'b0, "trace before int");
      run_exc(8'h05, 4'h3);
      check(wr_data, 32'h0000_0080, "saved trace flag");
      pulse(8'h01);
      watch(took, acked);
      check(acked, 1'b1, "int after trace");
      int_pending = 1'b0;
      run_exc(8'h11, 4'h3);
      $display("Test trace done");
   endtask : t_trace
   task automatic t_wdt();
      // Watchdog and trap in one cycle: the reset must win
      pulse(8'hC0);
      reset_seq();
      $display("Test watchdog done");
   endtask : t_wdt
   task automatic t_reserved();
      logic [7:0] bad_vec [6] = '{8'h01, 8'h02, 8'h06, 8'h0C, 8'h18, 8'h1F};
      for (int k = 0; k < 6; k++) begin
         int_pending = 1'b1;
         int_vec     = bad_vec[k];
         pulse(8'h01);
         pulse(8'h01);
         for (int i = 0; i < 40 && vec_error !== 1'b1; i++)
            @(negedge ref_clk);
         check(vec_error, 1'b1, "reserved vector");
         int_pending = 1'b0;
         pin_reset();
      end
      $display("Test reserved vectors done");
   endtask : t_reserved
   initial begin
      rst             = 1'b1;
      chip_clear_in_n = 1'b0;
      slow            = 1'b0;
      flags           = 8'h00;
      trap_num        = 2'h0;
      int_pending     = 1'b0;
      int_is_nmi      = 1'b0;
      int_vec         = 8'h00;
      int_mode_set    = 1'b0;
      int_mode_in     = 2'h0;
      ctl_write       = 1'b0;
      ccr_in          = 8'h80;
      exr_in          = 8'h00;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      pin_reset();
      t_int();
      t_ctl();
      t_trap();
      t_trace();
      t_wdt();
      t_reserved();
      wrap_up();
   end
endmodule : cpu_exception_sequencer_tb_top
`default_nettype wire

// ### bench/exs_bus_model.sv
// Memory beside the exception sequencer: stack writes and vector reads
`timescale 1ns/1ns
`default_nettype none
module exs_bus_model (
   // Clock and pacing
   input  wire logic        ref_clk,
   input  wire logic        slow,
   // Requests from the sequencer
   input  wire logic        bus_req,
   input  wire logic        bus_we,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_long,
   // Answers
   output logic             bus_ack,
   output logic [31:0]      bus_rdata,
   // Record of the last read and the writes before it
   output logic [31:0]      rd_addr,
   output logic             rd_long,
   output logic [3:0]       saves_seen,
   output logic [31:0]      wr_data
);
   int         wait_cnt = 0;
   logic [3:0] saves    = 4'h0;
   initial begin
      bus_ack    = 1'b0;
      bus_rdata  = 32'h0000_0000;
      rd_addr    = 32'hFFFF_FFFF;
      rd_long    = 1'b0;
      saves_seen = 4'h0;
      wr_data    = 32'h0000_0000;
   end
   // ----------------------------------------------------------------
   // Answer after one cycle, or five when slow
   // ----------------------------------------------------------------
   // Read data is the address plus an offset; it is inverted once the
   // answer is gone, so a late sample of it never looks valid
   always @(negedge ref_clk) begin
      if (bus_ack) begin
         bus_ack   <= 1'b0;
         bus_rdata <= ~bus_rdata;
         wait_cnt  <= 0;
      end else if (bus_req) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= (slow ? 5 : 1)) begin
            bus_ack <= 1'b1;
            if (bus_we) begin
               saves   <= saves + 4'h1;
               wr_data <= bus_wdata;
            end else begin
               bus_rdata  <= 32'h0000_1000 + bus_addr;
               rd_addr    <= bus_addr;
               rd_long    <= bus_long;
               saves_seen <= saves;
               saves      <= 4'h0;
            end
         end
      end else begin
         wait_cnt <= 0;
      end
   end
endmodule : exs_bus_model
`default_nettype wire

// ### hw/exs_arb_if.sv
// Interface between the sequencer and its priority picker
`timescale 1ns/1ns
`default_nettype none
interface exs_arb_if;
   import exs_pkg::*;
   logic        reset_req;
   logic        trace_req;
   logic        int_req;
   logic        trap_req;
   exs_src_type pick;
   modport seq (output reset_req, trace_req, int_req, trap_req,
                input pick);
   modport arb (input reset_req, trace_req, int_req, trap_req,
                output pick);
endinterface : exs_arb_if
`default_nettype wire

// ### hw/exs_arbiter.sv
// Fixed-priority picker of pending exceptions
`timescale 1ns/1ns
`default_nettype none
module exs_arbiter
   import exs_pkg::*;
(
   exs_arb_if.arb arb
);
   always_comb begin
      if (arb.reset_req)
         arb.pick = EXS_SRC_RESET;
      else if (arb.trace_req)
         arb.pick = EXS_SRC_TRACE;
      else if (arb.int_req)
         arb.pick = EXS_SRC_INT;
      else if (arb.trap_req)
         arb.pick = EXS_SRC_TRAP;
      else
         arb.pick = EXS_SRC_NONE;
   end
endmodule : exs_arbiter
`default_nettype wire

// ### hw/exs_pkg.sv
// Types shared by the exception sequencer modules
package exs_pkg;
   typedef enum logic [2:0] {
      EXS_SRC_NONE  = 3'b000,
      EXS_SRC_RESET = 3'b001,
      EXS_SRC_TRACE = 3'b010,
      EXS_SRC_INT   = 3'b011,
      EXS_SRC_TRAP  = 3'b100
   } exs_src_type;
endpackage : exs_pkg

// ### hw/exs_regs.svh
// Constants of the exception sequencer: vectors, reset values, timing
`ifndef EXS_REGS_SVH
`define EXS_REGS_SVH
`define EXS_VEC_RESET     8'h00
`define EXS_VEC_MRESET    8'h01
`define EXS_VEC_TRACE     8'h05
`define EXS_VEC_DIRECT    8'h06
`define EXS_VEC_NMI       8'h07
`define EXS_VEC_TRAP0     8'h08
`define EXS_VEC_IRQ0      8'h10
`define EXS_VEC_INT_FIRST 8'h20
`define EXS_VEC_INT_LAST  8'h76
`define EXS_SLOT_SHIFT    2
`define EXS_CLK_PERIOD_NS 10
`define EXS_RST_RUN_STATES 20
`define EXS_RST_PWR_MS    20
`define EXS_CCR_I_BIT     7
`define EXS_EXR_T_BIT     7
`define EXS_EXR_RESET     8'h07
`define EXS_CCR_RESET     8'h80
`define EXS_SAVE_WORDS    3
`endif

// ### hw/exs_sequencer.sv
// Exception sequencer top: priority, start points, reset and vector fetch
//
// Overview of operation
// - Accept pending exceptions in fixed priority order.
// - Reset starts on pin release or on watchdog while running.
// - Hold everything while reset pin low.
// - Trace at instruction end when trace flag set.
// - Trace only in mode 2, never after return.
// - Interrupt at instruction end when request pending.
// - No interrupt detection after control instructions, reset.
// - Trap instruction always starts trap handling; a reset, trace or interrupt picked in the same cycle drops it.
// - Every source has own vector number.
// - Reserved vector numbers serve no source; an interrupt with one is flagged but still fetched.
// - Manual reset and direct-transition vectors unused.
// - Vector addresses are low sixteen bits.
// - Reset clears trace, sets interrupt masks.
// - Load reset vector into program counter.
// - Interrupt control mode zero after reset.
// - Block all interrupts until first instruction.
// - Save PC, CONDITION_CODE_REG, EXTENDED_CONTROL_REG before vector fetch, except on reset.
`timescale 1ns/1ns
`default_nettype none
`include "exs_regs.svh"
module exs_sequencer
   import exs_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Reset sources
   input  wire logic        chip_clear_in_n,
   input  wire logic        wdt_overflow,
   // Instruction sequencer boundary
   input  wire logic        instr_done,
   input  wire logic        return_from_exception_instr,
   input  wire logic        and_to_control_instr,
   input  wire logic        or_to_control_instr,
   input  wire logic        xor_to_control_instr,
   input  wire logic        load_control_instr,
   input  wire logic        trap_always_instr,
   input  wire logic [1:0]  trap_num,
   // Interrupt controller
   input  wire logic        int_pending,
   input  wire logic        int_is_nmi,
   input  wire logic [7:0]  int_vec,
   input  wire logic        int_mode_set,
   input  wire logic [1:0]  int_mode_in,
   // Control registers written by the core
   input  wire logic        ctl_write,
   input  wire logic [7:0]  ccr_in,
   input  wire logic [7:0]  exr_in,
   // Bus access handshake
   input  wire logic        bus_ack,
   input  wire logic [31:0] bus_rdata,
   // Bus requests
   output logic             bus_req,
   output logic             bus_we,
   output logic [31:0]      bus_addr,
   output logic [31:0]      bus_wdata,
   output logic             bus_long,
   // Core control and state
   output logic             cpu_halt,
   output logic             periph_init,
   output logic             pc_load,
   output logic [31:0]      pc_out,
   output logic [7:0]       condition_code_reg,
   output logic [7:0]       extended_control_reg,
   output logic [1:0]       int_mode,
   output logic             int_ack,
   output logic [7:0]       vec_num_out,
   output logic             exc_active,
   output logic             vec_error
);
   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_INIT  = 3'b001,
      ST_RUN   = 3'b010,
      ST_SAVE  = 3'b011,
      ST_FETCH = 3'b100,
      ST_LOAD  = 3'b101
   } exs_state_type;

   exs_arb_if arb_bus ();

   exs_state_type state_reg, state_next;
   exs_src_type   src_reg, src_next;
   logic [1:0]  save_cnt_reg, save_cnt_next;
   logic [31:0] sp_reg, sp_next;
   logic [31:0] pc_reg, pc_next;
   logic [7:0]  ccr_reg, ccr_next, exr_reg, exr_next;
   logic [1:0]  mode_reg, mode_next;
   logic        int_block_reg, int_block_next;
   logic        skip_int_reg, skip_int_next;
   logic        no_trace_reg, no_trace_next;
   logic        req_reg, req_next, we_reg, we_next, long_reg, long_next;
   logic [31:0] addr_reg, addr_next, wdata_reg, wdata_next;
   logic        halt_reg, halt_next, init_reg, init_next;
   logic        pcld_reg, pcld_next, ack_reg, ack_next;
   logic [7:0]  vnum_reg, vnum_next;
   logic        verr_reg, verr_next;
   logic        exc_reg, exc_next;
   logic [7:0]  map_num;
   logic [15:0] map_addr;
   logic        map_bad;
   logic        boundary;

   // ------------------------------------------------------------
   // Priority picker and vector map
   // ------------------------------------------------------------
   // ranking of requests
   exs_arbiter u_arb (.arb(arb_bus.arb));

   exs_vector_map u_map (
      .src       (state_reg == ST_RUN ? arb_bus.pick : src_reg),
      .trap_num  (trap_num),
      .int_is_nmi(int_is_nmi),
      .int_vec   (int_vec),
      .vec_num   (map_num),
      .vec_addr  (map_addr),
      .vec_bad   (map_bad)
   );

   assign boundary = instr_done && state_reg == ST_RUN;
   // reset request comes from the watchdog while running
   assign arb_bus.reset_req = wdt_overflow;
   // trace only in mode 2 and not after return
   assign arb_bus.trace_req = boundary && exr_reg[`EXS_EXR_T_BIT] &&
                              mode_reg == 2'd2 &&
                              !return_from_exception_instr && !no_trace_reg;
   assign arb_bus.int_req = boundary && int_pending && !int_block_reg &&
                            !skip_int_reg && !and_to_control_instr &&
                            !or_to_control_instr && !xor_to_control_instr &&
                            !load_control_instr;
   assign arb_bus.trap_req = state_reg == ST_RUN && trap_always_instr;

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      src_next = src_reg;
      save_cnt_next = save_cnt_reg;
      sp_next = sp_reg;
      pc_next = pc_reg;
      ccr_next = ccr_reg;
      exr_next = exr_reg;
      mode_next = mode_reg;
      int_block_next = int_block_reg;
      skip_int_next = skip_int_reg;
      no_trace_next = 1'b0;
      req_next = 1'b0;
      we_next = 1'b0;
      long_next = long_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      halt_next = 1'b0;
      init_next = 1'b0;
      pcld_next = 1'b0;
      ack_next = 1'b0;
      vnum_next = vnum_reg;
      verr_next = verr_reg;
      if (ctl_write && state_reg == ST_RUN) begin
         ccr_next = ccr_in;
         exr_next = exr_in;
      end
      if (int_mode_set && state_reg == ST_RUN)
         mode_next = int_mode_in;
      // pin low holds the reset state
      if (!chip_clear_in_n) begin
         state_next = ST_RESET;
         halt_next = 1'b1;
      end else begin
         unique case (state_reg)
            ST_RESET: begin
               state_next = ST_INIT;
               halt_next = 1'b1;
               init_next = 1'b1;
            end
            ST_INIT: begin
               exr_next = `EXS_EXR_RESET;
               ccr_next = `EXS_CCR_RESET;
               mode_next = 2'd0;
               int_block_next = 1'b1;
               src_next = EXS_SRC_RESET;
               vnum_next = `EXS_VEC_RESET;
               verr_next = 1'b0;
               // longword fetch of the reset vector
               req_next = 1'b1;
               long_next = 1'b1;
               addr_next = 32'h0000_0000;
               halt_next = 1'b1;
               state_next = ST_FETCH;
            end
            ST_RUN: begin
               if (instr_done) begin
                  int_block_next = 1'b0;
                  skip_int_next = 1'b0;
               end
               if (arb_bus.pick == EXS_SRC_RESET) begin
                  state_next = ST_INIT;
                  init_next = 1'b1;
                  halt_next = 1'b1;
               end else if (arb_bus.pick != EXS_SRC_NONE) begin
                  src_next = arb_bus.pick;
                  vnum_next = map_num;
                  verr_next = map_bad;
                  ack_next = arb_bus.pick == EXS_SRC_INT;
                  save_cnt_next = 2'd0;
                  state_next = ST_SAVE;
               end
            end
            ST_SAVE: begin
               // push PC, CONDITION_CODE_REG and EXTENDED_CONTROL_REG before the fetch
               if (!req_reg) begin
                  req_next = 1'b1;
                  we_next = 1'b1;
                  long_next = save_cnt_reg == 2'd0;
                  sp_next = sp_reg - 32'd4;
                  addr_next = sp_reg - 32'd4;
                  unique case (save_cnt_reg)
                     2'd0:    wdata_next = pc_reg;
                     2'd1:    wdata_next = {24'h00_0000, ccr_reg};
                     default: wdata_next = {24'h00_0000, exr_reg};
                  endcase
               end else if (!bus_ack) begin
                  req_next = 1'b1;
                  we_next = 1'b1;
               end else if (save_cnt_reg == 2'(`EXS_SAVE_WORDS - 1)) begin
                  ccr_next[`EXS_CCR_I_BIT] = 1'b1;
                  if (mode_reg == 2'd2)
                     exr_next[`EXS_EXR_T_BIT] = 1'b0;
                  addr_next = {16'h0000, map_addr};
                  long_next = 1'b1;
                  req_next = 1'b1;
                  state_next = ST_FETCH;
               end else
                  save_cnt_next = save_cnt_reg + 2'd1;
            end
            ST_FETCH: begin
               halt_next = src_reg == EXS_SRC_RESET;
               if (bus_ack) begin
                  pc_next = bus_rdata;
                  state_next = ST_LOAD;
               end else
                  req_next = 1'b1;
            end
            ST_LOAD: begin
               pcld_next = 1'b1;
               // no interrupt detection right after reset handling
               skip_int_next = src_reg == EXS_SRC_RESET;
               no_trace_next = 1'b1;
               state_next = ST_RUN;
            end
            default: begin
               state_next = ST_RESET;
               halt_next = 1'b1;
            end
         endcase
      end
      exc_next = state_next != ST_RUN;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= ST_RESET;
         src_reg <= EXS_SRC_NONE;
         save_cnt_reg <= 2'd0;
         sp_reg <= 32'h0000_0000;
         pc_reg <= 32'h0000_0000;
         ccr_reg <= `EXS_CCR_RESET;
         exr_reg <= `EXS_EXR_RESET;
         mode_reg <= 2'd0;
         int_block_reg <= 1'b1;
         skip_int_reg <= 1'b1;
         no_trace_reg <= 1'b0;
         req_reg <= 1'b0;
         we_reg <= 1'b0;
         long_reg <= 1'b0;
         addr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         halt_reg <= 1'b1;
         init_reg <= 1'b0;
         pcld_reg <= 1'b0;
         ack_reg <= 1'b0;
         vnum_reg <= 8'h00;
         verr_reg <= 1'b0;
         exc_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         src_reg <= src_next;
         save_cnt_reg <= save_cnt_next;
         sp_reg <= sp_next;
         pc_reg <= pc_next;
         ccr_reg <= ccr_next;
         exr_reg <= exr_next;
         mode_reg <= mode_next;
         int_block_reg <= int_block_next;
         skip_int_reg <= skip_int_next;
         no_trace_reg <= no_trace_next;
         req_reg <= req_next;
         we_reg <= we_next;
         long_reg <= long_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         halt_reg <= halt_next;
         init_reg <= init_next;
         pcld_reg <= pcld_next;
         ack_reg <= ack_next;
         vnum_reg <= vnum_next;
         verr_reg <= verr_next;
         exc_reg <= exc_next;
      end
   end

   assign bus_req = req_reg;
   assign bus_we = we_reg;
   assign bus_addr = addr_reg;
   assign bus_wdata = wdata_reg;
   assign bus_long = long_reg;
   assign cpu_halt = halt_reg;
   assign periph_init = init_reg;
   assign pc_load = pcld_reg;
   assign pc_out = pc_reg;
   assign condition_code_reg = ccr_reg;
   assign extended_control_reg = exr_reg;
   assign int_mode = mode_reg;
   assign int_ack = ack_reg;
   assign vec_num_out = vnum_reg;
   assign exc_active = exc_reg;
   assign vec_error = verr_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   reset_holds_a: assert property (@(posedge ref_clk) disable iff (rst)
      !chip_clear_in_n |=> cpu_halt && state_reg == ST_RESET)
      else $error("reset pin low but core not halted");
   reset_start_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(chip_clear_in_n) && state_reg == ST_RESET |=> periph_init)
      else $error("reset handling did not start on pin release");
   reset_masks_a: assert property (@(posedge ref_clk) disable iff (rst)
      state_reg == ST_INIT && chip_clear_in_n |=>
      condition_code_reg[`EXS_CCR_I_BIT] && int_mode == 2'd0 &&
      !extended_control_reg[`EXS_EXR_T_BIT])
      else $error("reset left wrong mask or trace state");
   reset_vec_a: assert property (@(posedge ref_clk) disable iff (rst)
      state_reg == ST_INIT && chip_clear_in_n |=>
      bus_req && bus_long && bus_addr == 32'h0000_0000)
      else $error("reset vector fetch not issued");
   trace_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
      boundary && (mode_reg != 2'd2 || return_from_exception_instr) |=>
      !(state_reg == ST_SAVE && src_reg == EXS_SRC_TRACE))
      else $error("trace taken outside mode 2 or after return");
   prio_order_a: assert property (@(posedge ref_clk) disable iff (rst)
      arb_bus.trace_req && arb_bus.int_req && !wdt_overflow |->
      arb_bus.pick == EXS_SRC_TRACE)
      else $error("interrupt beat trace");
   int_skip_a: assert property (@(posedge ref_clk) disable iff (rst)
      boundary && (and_to_control_instr || or_to_control_instr ||
      xor_to_control_instr || load_control_instr) |=> !int_ack)
      else $error("interrupt detected after control instruction");
   trap_take_a: assert property (@(posedge ref_clk) disable iff (rst)
      state_reg == ST_RUN && trap_always_instr && !wdt_overflow &&
      !arb_bus.trace_req && !arb_bus.int_req && chip_clear_in_n
      |=> state_reg == ST_SAVE && src_reg == EXS_SRC_TRAP)
      else $error("trap not started");
   slot_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
      state_reg == ST_FETCH |->
      bus_addr == {22'h00_0000, vec_num_out, 2'b00})
      else $error("slot address not number times four");
endmodule : exs_sequencer
`default_nettype wire

// ### hw/exs_vector_map.sv
// Vector number and vector slot address for each exception source
`timescale 1ns/1ns
`default_nettype none
`include "exs_regs.svh"
module exs_vector_map
   import exs_pkg::*;
(
   input  wire exs_src_type src,
   input  wire logic [1:0]  trap_num,
   input  wire logic        int_is_nmi,
   input  wire logic [7:0]  int_vec,
   output logic [7:0]       vec_num,
   output logic [15:0]      vec_addr,
   output logic             vec_bad
);
   function automatic logic vec_reserved(input logic [7:0] v);
      return (v >= 8'h02 && v <= 8'h04) || (v >= 8'h0C && v <= 8'h0F) ||
             (v >= 8'h18 && v <= 8'h1F) || v == `EXS_VEC_MRESET ||
             v == `EXS_VEC_DIRECT || v > `EXS_VEC_INT_LAST;
   endfunction : vec_reserved

   always_comb begin
      unique case (src)
         EXS_SRC_RESET: vec_num = `EXS_VEC_RESET;
         EXS_SRC_TRACE: vec_num = `EXS_VEC_TRACE;
         EXS_SRC_INT:   vec_num = int_is_nmi ? `EXS_VEC_NMI : int_vec;
         EXS_SRC_TRAP:  vec_num = `EXS_VEC_TRAP0 + {6'h00, trap_num};
         default:       vec_num = `EXS_VEC_RESET;
      endcase
      // Reserved numbers are flagged but still mapped to their slot
      vec_bad  = (src == EXS_SRC_INT) && !int_is_nmi &&
                 (vec_reserved(int_vec) || int_vec < `EXS_VEC_IRQ0);
      // low sixteen bits, table at zero
      vec_addr = {6'h00, vec_num, 2'b00};
   end
endmodule : exs_vector_map
`default_nettype wire
